// ==== rtl/tmf_pkg.sv ====
// Shared constants of the timer event flag and request enable block
package tmf_pkg;

	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam logic [7:0]  ENABLE_OFFSET = 8'h0c;
	localparam logic [7:0]  STATUS_OFFSET = 8'h10;
	localparam logic [15:0] ENABLE_RESET  = 16'h0000;
	localparam logic [15:0] STATUS_RESET  = 16'h0000;
	// Implemented bits; all others are reserved and read as zero
	localparam logic [15:0] ENABLE_MASK   = 16'h47e7;
	localparam logic [15:0] STATUS_MASK   = 16'h06e7;
	// Flags that have an interrupt enable at the same position
	localparam logic [15:0] IRQ_FLAG_MASK = 16'h00e7;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int UPDATE_BIT   = 0;
	localparam int CH1_BIT      = 1;
	localparam int CH2_BIT      = 2;
	localparam int COMM_BIT     = 5;
	localparam int TRIG_BIT     = 6;
	localparam int BREAK_BIT    = 7;
	localparam int UPD_DMA_BIT  = 8;
	localparam int CH1_DMA_BIT  = 9;
	localparam int CH2_DMA_BIT  = 10;
	localparam int TRIG_DMA_BIT = 14;
	localparam int CH1_OVC_BIT  = 9;
	localparam int CH2_OVC_BIT  = 10;

	// ---------------------------------------------------------------
	// Modes and bus answers
	// ---------------------------------------------------------------
	localparam logic       UPD_SRC_ANY = 1'b0;
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ==== rtl/tmf_flag_bank.sv ====
// Bank of sticky status flags with set-over-clear priority
`timescale 1ns/1ns
module tmf_flag_bank #(
	parameter int              WIDTH = 16,
	parameter logic [WIDTH-1:0] IMPL  = '1,
	parameter logic [WIDTH-1:0] RESET = '0
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] set,
	input  wire logic [WIDTH-1:0] clr,
	output logic      [WIDTH-1:0] q
);

	logic [WIDTH-1:0] flag_d;
	logic [WIDTH-1:0] flag_q;

	// ---------------------------------------------------------------
	// Elaboration check
	// ---------------------------------------------------------------
	if (WIDTH < 1 || WIDTH > 32)
	begin : g_bad_width
		$error("flag bank width must be 1 to 32");
	end

	// ---------------------------------------------------------------
	// Next state per bit
	// ---------------------------------------------------------------
	// Set wins so an event in the clearing cycle is never lost
	for (genvar i = 0; i < WIDTH; i++)
	begin : g_flag
		if (IMPL[i])
		begin : g_impl
			assign flag_d[i] = set[i] | (flag_q[i] & ~clr[i]);
		end
		else
		begin : g_rsvd
			assign flag_d[i] = 1'b0;
		end
	end

	// Register the flags
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			flag_q <= RESET;
		else
			flag_q <= flag_d;
	end

	assign q = flag_q;

endmodule

// ==== rtl/tmf_axil_slave.sv ====
// AXI4-Lite slave front end: handshakes, one write and one read in flight
`timescale 1ns/1ns
module tmf_axil_slave #(
	parameter int ADDR_W = 8
) (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              wvalid,
	output logic                   wready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	output logic                   bvalid,
	input  wire logic              bready,
	output logic      [1:0]        bresp,
	input  wire logic              arvalid,
	output logic                   arready,
	input  wire logic [ADDR_W-1:0] araddr,
	output logic                   rvalid,
	input  wire logic              rready,
	output logic      [31:0]       rdata,
	output logic      [1:0]        rresp,
	output logic                   reg_wr,
	output logic      [ADDR_W-1:0] reg_wr_addr,
	output logic      [31:0]       reg_wr_data,
	output logic      [3:0]        reg_wr_strb,
	input  wire logic              reg_wr_ok,
	output logic                   reg_rd,
	output logic      [ADDR_W-1:0] reg_rd_addr,
	input  wire logic [31:0]       reg_rd_data,
	input  wire logic              reg_rd_ok
);

	logic              aw_full_q, aw_full_d;
	logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
	logic              w_full_q, w_full_d;
	logic [31:0]       w_data_q, w_data_d;
	logic [3:0]        w_strb_q, w_strb_d;
	logic              bvalid_q, bvalid_d;
	logic [1:0]        bresp_q, bresp_d;
	logic              rvalid_q, rvalid_d;
	logic [31:0]       rdata_q, rdata_d;
	logic [1:0]        rresp_q, rresp_d;

	// ---------------------------------------------------------------
	// Handshake outputs
	// ---------------------------------------------------------------
	// Address and data are held apart so they may come in either order
	assign awready     = !aw_full_q;
	assign wready      = !w_full_q;
	assign arready     = !rvalid_q;
	// Write commits once both halves are held and no answer is pending
	assign reg_wr      = aw_full_q & w_full_q & !bvalid_q;
	assign reg_wr_addr = aw_addr_q;
	assign reg_wr_data = w_data_q;
	assign reg_wr_strb = w_strb_q;
	assign reg_rd      = arvalid & !rvalid_q;
	assign reg_rd_addr = araddr;
	assign bvalid      = bvalid_q;
	assign bresp       = bresp_q;
	assign rvalid      = rvalid_q;
	assign rdata       = rdata_q;
	assign rresp       = rresp_q;

	// Next state of both channels
	always_comb
	begin
		aw_full_d = aw_full_q;
		aw_addr_d = aw_addr_q;
		w_full_d  = w_full_q;
		w_data_d  = w_data_q;
		w_strb_d  = w_strb_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		rvalid_d  = rvalid_q;
		rdata_d   = rdata_q;
		rresp_d   = rresp_q;
		if (awvalid && awready)
		begin
			aw_full_d = 1'b1;
			aw_addr_d = awaddr;
		end
		if (wvalid && wready)
		begin
			w_full_d = 1'b1;
			w_data_d = wdata;
			w_strb_d = wstrb;
		end
		if (bvalid_q && bready)
			bvalid_d = 1'b0;
		if (reg_wr)
		begin
			aw_full_d = 1'b0;
			w_full_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = reg_wr_ok ? tmf_pkg::RESP_OKAY : tmf_pkg::RESP_SLVERR;
		end
		if (rvalid_q && rready)
			rvalid_d = 1'b0;
		if (reg_rd)
		begin
			rvalid_d = 1'b1;
			rdata_d  = reg_rd_ok ? reg_rd_data : 32'h0000_0000;
			rresp_d  = reg_rd_ok ? tmf_pkg::RESP_OKAY : tmf_pkg::RESP_SLVERR;
		end
	end

	// Register both channels
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aw_full_q <= 1'b0;
			aw_addr_q <= '0;
			w_full_q  <= 1'b0;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= 2'h0;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= 2'h0;
		end
		else
		begin
			aw_full_q <= aw_full_d;
			aw_addr_q <= aw_addr_d;
			w_full_q  <= w_full_d;
			w_data_q  <= w_data_d;
			w_strb_q  <= w_strb_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			rvalid_q  <= rvalid_d;
			rdata_q   <= rdata_d;
			rresp_q   <= rresp_d;
		end
	end

endmodule

// ==== rtl/tmf_event_flags.sv ====
// Timer event flags, interrupt and DMA request enables, AXI4-Lite registers
// Operation
// - Enable bits 0, 1, 2, 5, 6, 7 enable the update, channel 1, channel 2,
//     commutation, trigger and break interrupts, 1 meaning enabled.
// - Enable bits 8, 9, 10, 14 enable update, channel 1, channel 2 and trigger DMA requests.
// - Status bit 0 is set by every update event and cleared by writing 0.
// - A repetition counter wrap raises an update event unless updates are disabled.
// - An update-generate command raises an update event when allowed and the source select is 0.
// - A counter reinit by trigger raises an update event when allowed and the source select is 0.
// - In output mode status bit 1 is set on a channel 1 compare match.
// - In input mode status bit 1 is set on each capture and cleared by writing 0 or a capture read.
// - Status bit 2 does the same for channel 2.
// - Status bit 5 is set by a commutation event and held until written 0.
// - Status bit 6 is set by a trigger event and cleared by writing 0.
// - Status bit 7 is set while break is active and a clear only works once break is gone.
// - Status bit 9 is set when a channel 1 capture finds its flag still set, input mode only.
// - Status bit 10 does the same for channel 2.
// - Status bits 4:3, 8 and 15:11 are reserved and never set.
`timescale 1ns/1ns
module tmf_event_flags #(
	parameter int ADDR_W = 8
) (
	input  wire logic              CLK,
	input  wire logic              RSTN,
	// AXI4-Lite register port
	input  wire logic              AWVALID,
	output logic                   AWREADY,
	input  wire logic [ADDR_W-1:0] AWADDR,
	input  wire logic [2:0]        AWPROT,
	input  wire logic              WVALID,
	output logic                   WREADY,
	input  wire logic [31:0]       WDATA,
	input  wire logic [3:0]        WSTRB,
	output logic                   BVALID,
	input  wire logic              BREADY,
	output logic      [1:0]        BRESP,
	input  wire logic              ARVALID,
	output logic                   ARREADY,
	input  wire logic [ADDR_W-1:0] ARADDR,
	input  wire logic [2:0]        ARPROT,
	output logic                   RVALID,
	input  wire logic              RREADY,
	output logic      [31:0]       RDATA,
	output logic      [1:0]        RRESP,
	// Timer core controls and event strobes
	input  wire logic              UPDATE_DISABLE,
	input  wire logic              UPDATE_SOURCE_SELECT,
	input  wire logic              REP_WRAP,
	input  wire logic              UPDATE_GENERATE,
	input  wire logic              TRIGGER_REINIT,
	input  wire logic              CH1_IS_INPUT,
	input  wire logic              CH2_IS_INPUT,
	input  wire logic              CH1_MATCH,
	input  wire logic              CH2_MATCH,
	input  wire logic              CH1_CAPTURE,
	input  wire logic              CH2_CAPTURE,
	input  wire logic              CH1_CAPTURE_READ,
	input  wire logic              CH2_CAPTURE_READ,
	input  wire logic              COMMUTATION_EVENT,
	input  wire logic              TRIGGER_EVENT,
	input  wire logic              BREAK_ACTIVE,
	// Requests toward counter, interrupt and DMA controllers
	output logic                   UPDATE_EVENT,
	output logic                   IRQ,
	output logic                   DMA_REQ_UPDATE,
	output logic                   DMA_REQ_CH1,
	output logic                   DMA_REQ_CH2,
	output logic                   DMA_REQ_TRIGGER
);

	// ---------------------------------------------------------------
	// Elaboration check
	// ---------------------------------------------------------------
	if (ADDR_W < 5 || ADDR_W > 32)
	begin : g_bad_addr
		$error("ADDR_W must be 5 to 32");
	end

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	logic              reg_wr;
	logic [ADDR_W-1:0] reg_wr_addr;
	logic [31:0]       reg_wr_data;
	logic [3:0]        reg_wr_strb;
	logic              reg_wr_ok;
	logic              reg_rd;
	logic [ADDR_W-1:0] reg_rd_addr;
	logic [31:0]       reg_rd_data;
	logic              reg_rd_ok;
	logic [1:0]        wr_hit;
	logic [1:0]        rd_hit;
	logic [15:0]       lane_mask;
	logic [15:0]       enable_q, enable_d;
	logic [15:0]       status_q;
	logic [15:0]       set_vec;
	logic [15:0]       clr_vec;
	logic              upd_evt;
	logic              ch1_evt;
	logic              ch2_evt;
	logic              irq_q, irq_d;
	logic [4:0]        req_q, req_d;

	// Map an address onto the two registers: bit 0 enable, bit 1 status
	function automatic logic [1:0] decode(input logic [ADDR_W-1:0] addr);
		logic [1:0] hit;
		hit    = 2'b00;
		hit[0] = (addr == ADDR_W'(tmf_pkg::ENABLE_OFFSET));
		hit[1] = (addr == ADDR_W'(tmf_pkg::STATUS_OFFSET));
		return hit;
	endfunction

	// ---------------------------------------------------------------
	// Bus front end
	// ---------------------------------------------------------------
	// Protection attributes are accepted but do not restrict access
	tmf_axil_slave #(
		.ADDR_W (ADDR_W)
	) u_bus (
		.clk         (CLK),
		.rst_n       (RSTN),
		.awvalid     (AWVALID),
		.awready     (AWREADY),
		.awaddr      (AWADDR),
		.wvalid      (WVALID),
		.wready      (WREADY),
		.wdata       (WDATA),
		.wstrb       (WSTRB),
		.bvalid      (BVALID),
		.bready      (BREADY),
		.bresp       (BRESP),
		.arvalid     (ARVALID),
		.arready     (ARREADY),
		.araddr      (ARADDR),
		.rvalid      (RVALID),
		.rready      (RREADY),
		.rdata       (RDATA),
		.rresp       (RRESP),
		.reg_wr      (reg_wr),
		.reg_wr_addr (reg_wr_addr),
		.reg_wr_data (reg_wr_data),
		.reg_wr_strb (reg_wr_strb),
		.reg_wr_ok   (reg_wr_ok),
		.reg_rd      (reg_rd),
		.reg_rd_addr (reg_rd_addr),
		.reg_rd_data (reg_rd_data),
		.reg_rd_ok   (reg_rd_ok)
	);

	// Address decode; any other address answers SLVERR
	assign wr_hit    = decode(reg_wr_addr);
	assign rd_hit    = decode(reg_rd_addr);
	assign reg_wr_ok = |wr_hit;
	assign reg_rd_ok = |rd_hit;
	// Only the two low byte lanes hold register bits
	assign lane_mask = {{8{reg_wr_strb[1]}}, {8{reg_wr_strb[0]}}};

	// Read data, reserved bits as zero
	always_comb
	begin
		reg_rd_data = 32'h0000_0000;
		if (rd_hit[0])
			reg_rd_data = {16'h0000, enable_q};
		else if (rd_hit[1])
			reg_rd_data = {16'h0000, status_q};
	end

	// ---------------------------------------------------------------
	// Enable register
	// ---------------------------------------------------------------
	// Byte lanes update independently; reserved bits never store
	always_comb
	begin
		enable_d = enable_q;
		if (reg_wr && wr_hit[0])
		begin
			enable_d = (enable_q & ~lane_mask) | (reg_wr_data[15:0] & lane_mask);
			enable_d = enable_d & tmf_pkg::ENABLE_MASK;
		end
	end

	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
			enable_q <= tmf_pkg::ENABLE_RESET;
		else
			enable_q <= enable_d;
	end

	// ---------------------------------------------------------------
	// Event qualification
	// ---------------------------------------------------------------
	// Repetition wrap needs only updates allowed; software and trigger
	// reinit additionally need the source select at zero
	assign upd_evt = !UPDATE_DISABLE
		& (REP_WRAP
		| ((UPDATE_SOURCE_SELECT == tmf_pkg::UPD_SRC_ANY)
		& (UPDATE_GENERATE
		| TRIGGER_REINIT)));
	// Channel flags follow compare in output mode, capture in input mode
	assign ch1_evt = CH1_IS_INPUT ? CH1_CAPTURE : CH1_MATCH;
	assign ch2_evt = CH2_IS_INPUT ? CH2_CAPTURE : CH2_MATCH;

	// ---------------------------------------------------------------
	// Status flags
	// ---------------------------------------------------------------
	// Hardware set sources per flag
	always_comb
	begin
		set_vec                        = 16'h0000;
		set_vec[tmf_pkg::UPDATE_BIT]   = upd_evt;
		set_vec[tmf_pkg::CH1_BIT]      = ch1_evt;
		set_vec[tmf_pkg::CH2_BIT]      = ch2_evt;
		set_vec[tmf_pkg::COMM_BIT]     = COMMUTATION_EVENT;
		set_vec[tmf_pkg::TRIG_BIT]     = TRIGGER_EVENT;
		// Level set keeps the flag pinned while break persists
		set_vec[tmf_pkg::BREAK_BIT]    = BREAK_ACTIVE;
		// Over-capture looks at the flag before this capture lands
		set_vec[tmf_pkg::CH1_OVC_BIT]  = CH1_IS_INPUT & CH1_CAPTURE
			& status_q[tmf_pkg::CH1_BIT];
		set_vec[tmf_pkg::CH2_OVC_BIT]  = CH2_IS_INPUT & CH2_CAPTURE
			& status_q[tmf_pkg::CH2_BIT];
	end

	// Clear sources: written zeros in enabled lanes, capture reads
	always_comb
	begin
		clr_vec = 16'h0000;
		if (reg_wr && wr_hit[1])
			clr_vec = ~reg_wr_data[15:0] & lane_mask;
		if (CH1_IS_INPUT && CH1_CAPTURE_READ)
			clr_vec[tmf_pkg::CH1_BIT] = 1'b1;
		if (CH2_IS_INPUT && CH2_CAPTURE_READ)
			clr_vec[tmf_pkg::CH2_BIT] = 1'b1;
		// A clear during break is dropped, not deferred
		if (BREAK_ACTIVE)
			clr_vec[tmf_pkg::BREAK_BIT] = 1'b0;
	end

	// Sticky flags; reserved positions are tied off inside the bank
	tmf_flag_bank #(
		.WIDTH (16),
		.IMPL  (tmf_pkg::STATUS_MASK),
		.RESET (tmf_pkg::STATUS_RESET)
	) u_flags (
		.clk   (CLK),
		.rst_n (RSTN),
		.set   (set_vec),
		.clr   (clr_vec),
		.q     (status_q)
	);

	// ---------------------------------------------------------------
	// Interrupt and DMA requests
	// ---------------------------------------------------------------
	// Interrupt is a level from the flags, so it drops once cleared
	always_comb
	begin
		irq_d = |(status_q & enable_q & tmf_pkg::IRQ_FLAG_MASK);
		// DMA requests are one-cycle pulses per qualifying event
		req_d[0] = upd_evt & enable_q[tmf_pkg::UPD_DMA_BIT];
		req_d[1] = ch1_evt & enable_q[tmf_pkg::CH1_DMA_BIT];
		req_d[2] = ch2_evt & enable_q[tmf_pkg::CH2_DMA_BIT];
		req_d[3] = TRIGGER_EVENT & enable_q[tmf_pkg::TRIG_DMA_BIT];
		req_d[4] = upd_evt;
	end

	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			irq_q <= 1'b0;
			req_q <= 5'h00;
		end
		else
		begin
			irq_q <= irq_d;
			req_q <= req_d;
		end
	end

	assign IRQ             = irq_q;
	assign DMA_REQ_UPDATE  = req_q[0];
	assign DMA_REQ_CH1     = req_q[1];
	assign DMA_REQ_CH2     = req_q[2];
	assign DMA_REQ_TRIGGER = req_q[3];
	// Qualified update strobe back to the counter for reinit
	assign UPDATE_EVENT    = req_q[4];

endmodule

// ==== testbench/tmf_req_sink.sv ====
// Request sink standing in for the DMA controller
`timescale 1ns/1ns
module tmf_req_sink (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        dma_upd,
	input  wire logic        dma_ch1,
	input  wire logic        dma_ch2,
	input  wire logic        dma_trig,
	output logic      [31:0] cnt
);
	// --------
	// Counting
	// --------
	// One byte per source; a request is a pulse, so a held level shows as a burst
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			cnt <= '0;
		else
			cnt <= cnt + {7'h00, dma_trig, 7'h00, dma_ch2, 7'h00, dma_ch1, 7'h00, dma_upd};
endmodule

// ==== testbench/tmf_event_flags_properties.sv ====
// Concurrent checks on the ports of the timer event flag block
`timescale 1ns/1ns
module tmf_event_flags_chk (
	input wire logic        CLK,
	input wire logic        RSTN,
	input wire logic        BVALID,
	input wire logic        BREADY,
	input wire logic [1:0]  BRESP,
	input wire logic        RVALID,
	input wire logic        RREADY,
	input wire logic [31:0] RDATA,
	input wire logic [1:0]  RRESP,
	input wire logic        UPDATE_DISABLE,
	input wire logic        UPDATE_SOURCE_SELECT,
	input wire logic        REP_WRAP,
	input wire logic        UPDATE_GENERATE,
	input wire logic        TRIGGER_REINIT,
	input wire logic        CH1_IS_INPUT,
	input wire logic        CH2_IS_INPUT,
	input wire logic        CH1_MATCH,
	input wire logic        CH2_MATCH,
	input wire logic        CH1_CAPTURE,
	input wire logic        CH2_CAPTURE,
	input wire logic        TRIGGER_EVENT,
	input wire logic        UPDATE_EVENT,
	input wire logic        DMA_REQ_UPDATE,
	input wire logic        DMA_REQ_CH1,
	input wire logic        DMA_REQ_CH2,
	input wire logic        DMA_REQ_TRIGGER
);
	// --------
	// Causes
	// --------
	// Qualified causes, one cycle ahead of the registered outputs
	wire logic upd_c = !UPDATE_DISABLE && (REP_WRAP
		|| (!UPDATE_SOURCE_SELECT && (UPDATE_GENERATE || TRIGGER_REINIT)));
	wire logic ch1_c = CH1_IS_INPUT ? CH1_CAPTURE : CH1_MATCH;
	wire logic ch2_c = CH2_IS_INPUT ? CH2_CAPTURE : CH2_MATCH;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);
	sequence s_upd_cause;
		upd_c;
	endsequence
	sequence s_b_wait;
		BVALID && !BREADY;
	endsequence
	// --------
	// Checks
	// --------
	chk_upd_follow: assert property (s_upd_cause |=> UPDATE_EVENT)
		else $error("update event missing after its cause");
	chk_upd_cause: assert property (UPDATE_EVENT |-> $past(upd_c))
		else $error("update event without a qualified cause");
	chk_dma_upd: assert property (DMA_REQ_UPDATE |-> $past(upd_c) && UPDATE_EVENT)
		else $error("update request without update event");
	chk_dma_ch1: assert property (DMA_REQ_CH1 |-> $past(ch1_c))
		else $error("channel 1 request without its event");
	chk_dma_ch2: assert property (DMA_REQ_CH2 |-> $past(ch2_c))
		else $error("channel 2 request without its event");
	chk_dma_trig: assert property (DMA_REQ_TRIGGER |-> $past(TRIGGER_EVENT))
		else $error("trigger request without trigger event");
	chk_b_hold: assert property (s_b_wait |=> BVALID && $stable(BRESP))
		else $error("write response dropped before taken");
	chk_r_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP))
		else $error("read answer changed before taken");
	chk_rd_upper: assert property (RVALID |-> RDATA[31:16] == 16'h0000)
		else $error("read data upper half not zero");
endmodule

bind tmf_event_flags tmf_event_flags_chk u_chk (
	.CLK, .RSTN, .BVALID, .BREADY, .BRESP, .RVALID, .RREADY, .RDATA, .RRESP,
	.UPDATE_DISABLE, .UPDATE_SOURCE_SELECT, .REP_WRAP, .UPDATE_GENERATE, .TRIGGER_REINIT,
	.CH1_IS_INPUT, .CH2_IS_INPUT, .CH1_MATCH, .CH2_MATCH, .CH1_CAPTURE, .CH2_CAPTURE,
	.TRIGGER_EVENT, .UPDATE_EVENT, .DMA_REQ_UPDATE, .DMA_REQ_CH1, .DMA_REQ_CH2,
	.DMA_REQ_TRIGGER
);

// ==== testbench/tmf_event_flags_tb.sv ====
// Self-checking bench for the timer event flag block
`timescale 1ns/1ns
module tmf_event_flags_tb;
	localparam logic [7:0] EN  = tmf_pkg::ENABLE_OFFSET;
	localparam logic [7:0] ST  = tmf_pkg::STATUS_OFFSET;
	localparam logic [1:0] OK  = tmf_pkg::RESP_OKAY;
	localparam logic [1:0] ERR = tmf_pkg::RESP_SLVERR;
	logic        clk, rstn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, upd_ev, irq, dq_u, dq_1, dq_2, dq_t;
	logic        upd_dis, upd_sel, ch1_in, ch2_in, brk;
	logic [1:0]  bresp, rresp;
	logic [7:0]  awaddr, araddr;
	logic [10:0] ev;
	logic [31:0] wdata, rdata, cnt;
	logic [3:0]  wstrb;
	int          error_cnt, cmp_count, cyc;
	int          evb [7] = '{0, 1, 2, 3, 4, 9, 10};
	int          flg [7] = '{0, 0, 0, 1, 2, 5, 6};

	tmf_event_flags #(.ADDR_W(8)) u_dut (.CLK(clk), .RSTN(rstn),
		.AWVALID(awvalid), .AWREADY(awready), .AWADDR(awaddr), .AWPROT(3'h0),
		.WVALID(wvalid), .WREADY(wready), .WDATA(wdata), .WSTRB(wstrb),
		.BVALID(bvalid), .BREADY(bready), .BRESP(bresp), .ARVALID(arvalid),
		.ARREADY(arready), .ARADDR(araddr), .ARPROT(3'h0), .RVALID(rvalid),
		.RREADY(rready), .RDATA(rdata), .RRESP(rresp), .UPDATE_DISABLE(upd_dis),
		.UPDATE_SOURCE_SELECT(upd_sel), .REP_WRAP(ev[0]), .UPDATE_GENERATE(ev[1]),
		.TRIGGER_REINIT(ev[2]), .CH1_IS_INPUT(ch1_in), .CH2_IS_INPUT(ch2_in),
		.CH1_MATCH(ev[3]), .CH2_MATCH(ev[4]), .CH1_CAPTURE(ev[5]), .CH2_CAPTURE(ev[6]),
		.CH1_CAPTURE_READ(ev[7]), .CH2_CAPTURE_READ(ev[8]), .COMMUTATION_EVENT(ev[9]),
		.TRIGGER_EVENT(ev[10]), .BREAK_ACTIVE(brk), .UPDATE_EVENT(upd_ev), .IRQ(irq),
		.DMA_REQ_UPDATE(dq_u), .DMA_REQ_CH1(dq_1), .DMA_REQ_CH2(dq_2),
		.DMA_REQ_TRIGGER(dq_t));
	tmf_req_sink u_sink (.clk(clk), .rst_n(rstn), .dma_upd(dq_u), .dma_ch1(dq_1),
		.dma_ch2(dq_2), .dma_trig(dq_t), .cnt(cnt));

	// --------
	// Tasks
	// --------
	task automatic stop_test;
		if (error_cnt == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
			error_cnt++;
		end
	endtask
	// Address and data offered together, each dropped once taken
	// Answers are accepted a cycle late so the hold checks see a stall
	task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
		@(posedge clk);
		awaddr <= a;
		wdata <= {16'h0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do
		begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (bvalid)
				bready <= 1'b1;
		end while (!(bvalid && bready));
		bready <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, bresp});
	endtask
	task automatic rc(input logic [7:0] a, input logic [15:0] e, input logic [1:0] er);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		do
		begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'b0;
			if (rvalid)
				rready <= 1'b1;
		end while (!(rvalid && rready));
		rready <= 1'b0;
		chk("rresp", {30'h0, er}, {30'h0, rresp});
		chk("rdata", {16'h0000, e}, rdata);
	endtask
	task automatic pulse(input int b);
		@(posedge clk);
		ev[b] <= 1'b1;
		@(posedge clk);
		ev[b] <= 1'b0;
	endtask

	// Free-running clock; the watchdog cuts a hung handshake short
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			error_cnt++;
			stop_test();
		end
	end

	// --------
	// Sequence
	// --------
	initial
	begin
		{awvalid, wvalid, bready, arvalid, rready, upd_dis, upd_sel, ch1_in, ch2_in, brk} = '0;
		{awaddr, araddr, wdata, ev} = '0;
		{rstn, error_cnt, cmp_count, cyc} = '0;
		wstrb = 4'h3;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rc(EN, 16'h0000, OK);
		rc(ST, 16'h0000, OK);
		wr(EN, 16'hffff, OK);
		rc(EN, 16'h47e7, OK);
		wr(EN, 16'h00e7, OK);
		wr(8'h0d, 16'hffff, ERR);
		rc(EN, 16'h00e7, OK);
		// Upper byte lane alone leaves the lower byte untouched
		wstrb <= 4'h2;
		wr(EN, 16'h4700, OK);
		rc(EN, 16'h47e7, OK);
		wr(EN, 16'h0000, OK);
		rc(EN, 16'h00e7, OK);
		wstrb <= 4'h3;
		rc(8'h04, 16'h0000, ERR);
		wr(ST, 16'hffff, OK);
		rc(ST, 16'h0000, OK);
		// Each event source but capture and break sets its flag and interrupts, then is cleared
		for (int i = 0; i < 7; i++)
		begin
			pulse(evb[i]);
			rc(ST, 16'h0001 << flg[i], OK);
			chk("irq", 32'h1, {31'h0, irq});
			wr(ST, ~(16'h0001 << flg[i]), OK);
			rc(ST, 16'h0000, OK);
			chk("irq", 32'h0, {31'h0, irq});
		end
		pulse(9);
		pulse(10);
		wr(ST, 16'hffdf, OK);
		rc(ST, 16'h0040, OK);
		wr(ST, 16'h0000, OK);
		upd_dis <= 1'b1;
		pulse(0);
		pulse(1);
		pulse(2);
		rc(ST, 16'h0000, OK);
		upd_dis <= 1'b0;
		upd_sel <= 1'b1;
		pulse(1);
		pulse(2);
		rc(ST, 16'h0000, OK);
		pulse(0);
		rc(ST, 16'h0001, OK);
		upd_sel <= 1'b0;
		brk <= 1'b1;
		wr(ST, 16'h0000, OK);
		rc(ST, 16'h0080, OK);
		brk <= 1'b0;
		wr(ST, 16'h0000, OK);
		rc(ST, 16'h0000, OK);
		// Double capture marks over-capture; a capture read clears only the flag
		ch1_in <= 1'b1;
		ch2_in <= 1'b1;
		for (int c = 0; c < 2; c++)
		begin
			pulse(5 + c);
			pulse(5 + c);
			rc(ST, 16'h0202 << c, OK);
			pulse(7 + c);
			rc(ST, 16'h0200 << c, OK);
			wr(ST, 16'h0000, OK);
		end
		wr(EN, 16'h4700, OK);
		ch1_in <= 1'b0;
		ch2_in <= 1'b0;
		pulse(0);
		pulse(3);
		pulse(4);
		pulse(10);
		ch1_in <= 1'b1;
		pulse(5);
		rc(ST, 16'h0247, OK);
		chk("dma", 32'h01010201, cnt);
		chk("irq", 32'h0, {31'h0, irq});
		stop_test();
	end
endmodule
